// ### src/alu_engine.sv
// Integer ALU, multiplier, divider and multiply-accumulate engine
`timescale 1ns/1ps
module alu_engine (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Decoder request
  input wire alu_engine_pkg::req_t req,
  input wire alu_engine_pkg::core_setup_register_t core_setup_register,
  // Results
  output alu_engine_pkg::result_t result,
  output logic [4:0] processor_flags_register,
  output logic [39:0] acc_a,
  output logic [39:0] acc_b,
  output logic issue_stall
);
  // Whole engine state
  typedef struct packed {
    alu_engine_pkg::result_t res;
    logic [4:0] flags;
    logic [39:0] acc_a;
    logic [39:0] acc_b;
    logic stall;
  } eng_state_t;
  eng_state_t state_reg, state_next;
  logic div_busy;
  logic div_done;
  logic [15:0] div_q;
  logic [15:0] div_r;
  logic div_start;
  logic div_signed;
  logic div_wide;
  logic [16:0] ma;
  logic [16:0] mb;
  logic [33:0] prod;
  logic [39:0] prod_ext;
  logic [39:0] acc_cur;
  logic [39:0] acc_sum;
  logic [16:0] diff;
  logic [16:0] sum17;
  logic [15:0] logic_res;
  logic cout;
  logic dcout;
  logic ovf;
  logic [15:0] res16;
  alu_engine_pkg::op_t op;

  // Clamp a 40-bit value to the selected range
  function automatic logic [39:0] clamp(input logic [39:0] v, input logic wide_mode);
    logic [39:0] r;
    r = v;
    if (!wide_mode) begin
      if (!v[39] && v[39:31] != 9'h000) begin
        r = alu_engine_pkg::SAT_POS_31;
      end else if (v[39] && v[39:31] != 9'h1ff) begin
        r = alu_engine_pkg::SAT_NEG_31;
      end
    end
    return r;
  endfunction

  // Round the accumulator to its upper word
  function automatic logic [15:0] round_acc(input logic [39:0] v, input logic conv);
    logic [39:0] r;
    r = v + 40'h0000008000;
    if (conv && v[15:0] == 16'h8000 && !v[16]) begin
      r = v;
    end
    return r[31:16];
  endfunction

  assign op = req.op;
  assign div_start = req.valid && (op inside {alu_engine_pkg::OP_DIV_S32,
    alu_engine_pkg::OP_DIV_U32, alu_engine_pkg::OP_DIV_S16, alu_engine_pkg::OP_DIV_U16});
  assign div_signed = (op == alu_engine_pkg::OP_DIV_S32) || (op == alu_engine_pkg::OP_DIV_S16);
  assign div_wide = (op == alu_engine_pkg::OP_DIV_S32) || (op == alu_engine_pkg::OP_DIV_U32);

  // Divider; odd register of the aligned pair carries the upper half
  div_iter #(.STEPS(alu_engine_pkg::DIV_STEPS)) u_div (
    .core_clk(core_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .start(div_start),
    .signed_div(div_signed),
    .wide(div_wide),
    .dividend({req.a_hi, req.a}),
    .divisor(req.b),
    .busy(div_busy),
    .done(div_done),
    .quotient(div_q),
    .remainder(div_r)
  );

  // Shared 17x17 multiplier operand shaping
  always_comb begin
    diff = {req.a[15], req.a} - {req.b[15], req.b};
    ma = {1'b0, req.a};
    mb = {1'b0, req.b};
    unique case (op)
      alu_engine_pkg::OP_MUL_SS: begin
        ma = {req.a[15], req.a};
        mb = {req.b[15], req.b};
      end
      alu_engine_pkg::OP_MUL_US: mb = {req.b[15], req.b};
      alu_engine_pkg::OP_MUL_SL: begin
        ma = {req.a[15], req.a};
        mb = {12'h000, req.b[4:0]};
      end
      alu_engine_pkg::OP_MUL_UL: mb = {12'h000, req.b[4:0]};
      alu_engine_pkg::OP_MUL_B: begin
        ma = {9'h000, req.a[7:0]};
        mb = {9'h000, req.b[7:0]};
      end
      alu_engine_pkg::OP_ED, alu_engine_pkg::OP_SQUARED_DIFFERENCE_ACCUMULATE_OP: begin
        ma = diff;
        mb = diff;
      end
      alu_engine_pkg::OP_MAC, alu_engine_pkg::OP_MPY, alu_engine_pkg::OP_MSC: begin
        ma = {core_setup_register.multiply_sign_select ? 1'b0 : req.a[15], req.a};
        mb = {core_setup_register.multiply_sign_select ? 1'b0 : req.b[15], req.b};
      end
      default: begin
        ma = {1'b0, req.a};
        mb = {1'b0, req.b};
      end
    endcase
  end

  assign prod = 34'($signed(ma) * $signed(mb));
  // Fractional mode shifts the product left by one
  assign prod_ext = core_setup_register.fractional ? {{5{prod[33]}}, prod[33:0], 1'b0}
                                                   : {{6{prod[33]}}, prod};
  assign acc_cur = req.acc_sel ? state_reg.acc_b : state_reg.acc_a;

  // Integer datapath: byte or word, two's complement
  always_comb begin
    logic_res = 16'h0000;
    sum17 = 17'h0;
    cout = 1'b0;
    dcout = 1'b0;
    ovf = 1'b0;
    unique case (op)
      alu_engine_pkg::OP_ADD: begin
        sum17 = {1'b0, req.a} + {1'b0, req.b};
        dcout = (req.a[3:0] + req.b[3:0]) > 5'h0f ? 1'b1 : 1'b0;
      end
      alu_engine_pkg::OP_SUB: begin
        sum17 = {1'b0, req.a} - {1'b0, req.b};
        dcout = req.a[3:0] >= req.b[3:0];
      end
      alu_engine_pkg::OP_AND: logic_res = req.a & req.b;
      alu_engine_pkg::OP_IOR: logic_res = req.a | req.b;
      alu_engine_pkg::OP_XOR: logic_res = req.a ^ req.b;
      alu_engine_pkg::OP_SHL: logic_res = req.a << req.b[3:0];
      alu_engine_pkg::OP_LSR: logic_res = req.byte_mode ? {8'h00, req.a[7:0] >> req.b[3:0]}
                                                        : req.a >> req.b[3:0];
      alu_engine_pkg::OP_ASR: logic_res = req.byte_mode
        ? {8'h00, 8'($signed(req.a[7:0]) >>> req.b[3:0])}
        : 16'($signed(req.a) >>> req.b[3:0]);
      default: logic_res = 16'h0000;
    endcase
    res16 = (op == alu_engine_pkg::OP_ADD || op == alu_engine_pkg::OP_SUB) ? sum17[15:0]
                                                                             : logic_res;
    if (req.byte_mode) begin
      // Carry and overflow taken at bit 7 in byte mode
      res16 = {8'h00, res16[7:0]};
      cout = (op == alu_engine_pkg::OP_SUB) ? (req.a[7:0] >= req.b[7:0])
                                            : (9'(req.a[7:0]) + 9'(req.b[7:0])) > 9'h0ff;
      ovf = (op == alu_engine_pkg::OP_SUB) ? (req.a[7] != req.b[7]) && (res16[7] != req.a[7])
                                           : (req.a[7] == req.b[7]) && (res16[7] != req.a[7]);
    end else begin
      cout = (op == alu_engine_pkg::OP_SUB) ? ~sum17[16] : sum17[16];
      ovf = (op == alu_engine_pkg::OP_SUB) ? (req.a[15] != req.b[15]) && (res16[15] != req.a[15])
                                           : (req.a[15] == req.b[15]) && (res16[15] != req.a[15]);
    end
  end

  // Sequencing of all instructions
  always_comb begin
    state_next = state_reg;
    state_next.res.valid = 1'b0;
    state_next.res.wr2 = 1'b0;
    state_next.res.to_memory = req.to_memory;
    state_next.res.dest = 4'h0;
    state_next.stall = div_busy || div_start;
    acc_sum = acc_cur;
    if (div_done) begin
      state_next.res.valid = 1'b1;
      state_next.res.to_memory = 1'b0;
      state_next.res.dest = alu_engine_pkg::REG_QUOT;
      state_next.res.data = div_q;
      state_next.res.wr2 = 1'b1;
      state_next.res.data2 = div_r;
      state_next.stall = 1'b0;
    end else if (req.valid && !div_busy) begin
      // One instruction at a time; MAC ops never overlap integer ops
      unique case (op)
        alu_engine_pkg::OP_ADD, alu_engine_pkg::OP_SUB, alu_engine_pkg::OP_AND,
        alu_engine_pkg::OP_IOR, alu_engine_pkg::OP_XOR, alu_engine_pkg::OP_SHL,
        alu_engine_pkg::OP_LSR, alu_engine_pkg::OP_ASR: begin
          state_next.res.valid = 1'b1;
          state_next.res.data = res16;
          state_next.flags[alu_engine_pkg::FLAG_Z] = req.byte_mode ? (res16[7:0] == 8'h00)
                                                                  : (res16 == 16'h0000);
          state_next.flags[alu_engine_pkg::FLAG_N] = req.byte_mode ? res16[7] : res16[15];
          if (op == alu_engine_pkg::OP_ADD || op == alu_engine_pkg::OP_SUB) begin
            state_next.flags[alu_engine_pkg::FLAG_C] = cout;
            state_next.flags[alu_engine_pkg::FLAG_OV] = ovf;
            state_next.flags[alu_engine_pkg::FLAG_DC] = dcout;
          end
        end
        alu_engine_pkg::OP_MUL_SS, alu_engine_pkg::OP_MUL_UU, alu_engine_pkg::OP_MUL_US,
        alu_engine_pkg::OP_MUL_SL, alu_engine_pkg::OP_MUL_UL, alu_engine_pkg::OP_MUL_B: begin
          state_next.res.valid = 1'b1;
          state_next.res.dest = 4'h0;
          state_next.res.data = prod[15:0];
          state_next.res.wr2 = 1'b1;
          state_next.res.data2 = prod[31:16];
        end
        alu_engine_pkg::OP_MAC, alu_engine_pkg::OP_SQUARED_DIFFERENCE_ACCUMULATE_OP: acc_sum = acc_cur + prod_ext;
        alu_engine_pkg::OP_MPY, alu_engine_pkg::OP_ED: acc_sum = prod_ext;
        alu_engine_pkg::OP_MSC: acc_sum = acc_cur - prod_ext;
        alu_engine_pkg::OP_AADD: acc_sum = state_reg.acc_a + state_reg.acc_b;
        alu_engine_pkg::OP_ASUB: acc_sum = req.acc_sel ? state_reg.acc_b - state_reg.acc_a
                                                       : state_reg.acc_a - state_reg.acc_b;
        alu_engine_pkg::OP_ANEG: acc_sum = -acc_cur;
        default: acc_sum = acc_cur;
      endcase
      if (op inside {alu_engine_pkg::OP_MAC, alu_engine_pkg::OP_SQUARED_DIFFERENCE_ACCUMULATE_OP, alu_engine_pkg::OP_MPY,
          alu_engine_pkg::OP_ED, alu_engine_pkg::OP_MSC, alu_engine_pkg::OP_AADD,
          alu_engine_pkg::OP_ASUB, alu_engine_pkg::OP_ANEG}) begin
        if (req.acc_sel) begin
          state_next.acc_b = core_setup_register.acc_second_clamp_enable
            ? clamp(acc_sum, core_setup_register.clamp_mode_select) : acc_sum;
        end else begin
          state_next.acc_a = core_setup_register.acc_first_clamp_enable
            ? clamp(acc_sum, core_setup_register.clamp_mode_select) : acc_sum;
        end
        // Rounded write-back of the selected accumulator, as it was before this update, to memory
        if (req.to_memory) begin
          state_next.res.valid = 1'b1;
          state_next.res.data = round_acc(core_setup_register.memory_write_clamp_enable
            ? clamp(acc_cur, 1'b0) : acc_cur,
            core_setup_register.rounding_style_select);
        end
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign result = state_reg.res;
  assign processor_flags_register = state_reg.flags;
  assign acc_a = state_reg.acc_a;
  assign acc_b = state_reg.acc_b;
  assign issue_stall = state_reg.stall;

  a_div_writeback: assert property (@(posedge core_clk) disable iff (!nrst)
    (clk_en && div_done) |=> (result.valid && result.dest == alu_engine_pkg::REG_QUOT
    && result.wr2)) else $error("divide result not to quotient register");
  a_stall_held: assert property (@(posedge core_clk) disable iff (!nrst)
    (clk_en && div_busy && !div_done) |=> issue_stall) else $error("stall dropped");
  a_sub_borrow: assert property (@(posedge core_clk) disable iff (!nrst)
    (clk_en && req.valid && !div_busy && !div_done && op == alu_engine_pkg::OP_SUB
    && !req.byte_mode) |=> processor_flags_register[alu_engine_pkg::FLAG_C]
    == ($past(req.a) >= $past(req.b))) else $error("borrow flag wrong");
  a_zero_flag: assert property (@(posedge core_clk) disable iff (!nrst)
    (clk_en && req.valid && !div_busy && !div_done && op == alu_engine_pkg::OP_XOR
    && !req.byte_mode) |=> processor_flags_register[alu_engine_pkg::FLAG_Z]
    == ($past(req.a) == $past(req.b))) else $error("zero flag wrong");
  a_mul_unsigned: assert property (@(posedge core_clk) disable iff (!nrst)
    (clk_en && req.valid && !div_busy && !div_done && op == alu_engine_pkg::OP_MUL_UU)
    |=> {result.data2, result.data} == 32'($past(req.a)) * 32'($past(req.b)))
    else $error("unsigned product wrong");
  a_acc_neg: assert property (@(posedge core_clk) disable iff (!nrst)
    (clk_en && req.valid && !div_busy && !div_done && op == alu_engine_pkg::OP_ANEG
    && !req.acc_sel && !core_setup_register.acc_first_clamp_enable)
    |=> acc_a == 40'(-$past(acc_a))) else $error("negate wrong");
  a_clamp_range: assert property (@(posedge core_clk) disable iff (!nrst)
    (core_setup_register.acc_first_clamp_enable && !core_setup_register.clamp_mode_select
    && $changed(acc_a)) |-> (acc_a[39:31] == 9'h000 || acc_a[39:31] == 9'h1ff))
    else $error("clamp exceeded");
  a_add_width: assert property (@(posedge core_clk) disable iff (!nrst)
    (clk_en && req.valid && !div_busy && !div_done && op == alu_engine_pkg::OP_ADD
    && req.byte_mode) |=> result.data[15:8] == 8'h00) else $error("byte add wide");
endmodule

// ### src/alu_engine_pkg.sv
// Package with constants and carrier types for the arithmetic engine
// Contract
// - 16-bit add, subtract, shift, logic unit
// - Results in two's complement unless stated
// - Update carry, zero, negative, overflow, nibble flags
// - Subtract carry and nibble flags mean borrow
// - Operand width byte or word per instruction
// - Operands and results: registers or memory
// - Multiply reuses 17x17, all sign mixes
// - Six listed multiply modes supported
// - Divide 32/16 and 16/16, signed, unsigned
// - Quotient to register zero, remainder one
// - Divisor any register, dividend aligned pair
// - Divide iterates one cycle per divisor bit
// - MAC: 17x17, shifter, 40-bit adder, two accs
// - MAC never concurrent with independent integer ops
// - Accumulator add, subtract, negate need no data
// - Setup selects fractional, sign, rounding style
// - Separate clamp enables and clamp mode
package alu_engine_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned ACC_W = 40;
  localparam int unsigned DIV_STEPS = 16;
  localparam logic [3:0] REG_QUOT = 4'h0;
  localparam logic [3:0] REG_REM = 4'h1;
  // Flag positions inside the processor flags register
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_OV = 3;
  localparam int unsigned FLAG_DC = 4;
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam logic [39:0] ACC_RESET = 40'h0;
  localparam logic [39:0] SAT_POS_31 = 40'h007fffffff;
  localparam logic [39:0] SAT_NEG_31 = 40'hff80000000;
  localparam logic [39:0] SAT_POS_39 = 40'h7fffffffff;
  localparam logic [39:0] SAT_NEG_39 = 40'h8000000000;

  // Operation codes issued by the decoder
  typedef enum logic [4:0] {
    OP_ADD = 5'h00, OP_SUB = 5'h01, OP_AND = 5'h02, OP_IOR = 5'h03,
    OP_XOR = 5'h04, OP_SHL = 5'h05, OP_LSR = 5'h06, OP_ASR = 5'h07,
    OP_MUL_SS = 5'h08, OP_MUL_UU = 5'h09, OP_MUL_US = 5'h0a, OP_MUL_SL = 5'h0b,
    OP_MUL_UL = 5'h0c, OP_MUL_B = 5'h0d,
    OP_DIV_S32 = 5'h10, OP_DIV_U32 = 5'h11, OP_DIV_S16 = 5'h12, OP_DIV_U16 = 5'h13,
    OP_MAC = 5'h18, OP_MPY = 5'h19, OP_MSC = 5'h1a, OP_ED = 5'h1b, OP_SQUARED_DIFFERENCE_ACCUMULATE_OP = 5'h1c,
    OP_AADD = 5'h1d, OP_ASUB = 5'h1e, OP_ANEG = 5'h1f, OP_NOP = 5'h14
  } op_t;

  // Request from decoder: operands already fetched from registers or memory
  typedef struct packed {
    logic valid;
    op_t op;
    logic byte_mode;
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] a_hi;
    logic acc_sel;
    logic to_memory;
  } req_t;

  // Core setup register bits
  typedef struct packed {
    logic fractional;
    logic multiply_sign_select;
    logic rounding_style_select;
    logic acc_first_clamp_enable;
    logic acc_second_clamp_enable;
    logic memory_write_clamp_enable;
    logic clamp_mode_select;
  } core_setup_register_t;

  // Result toward the register file or memory
  typedef struct packed {
    logic valid;
    logic to_memory;
    logic [3:0] dest;
    logic [15:0] data;
    logic wr2;
    logic [15:0] data2;
  } result_t;
endpackage

// ### src/div_iter.sv
// Iterative restoring divider, one divisor bit per cycle
`timescale 1ns/1ps
module div_iter #(
  parameter int unsigned STEPS = alu_engine_pkg::DIV_STEPS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Request
  input wire logic start,
  input wire logic signed_div,
  input wire logic wide,
  input wire logic [31:0] dividend,
  input wire logic [15:0] divisor,
  // Answer
  output logic busy,
  output logic done,
  output logic [15:0] quotient,
  output logic [15:0] remainder
);
  // All divider state
  typedef struct packed {
    logic busy;
    logic done;
    logic [4:0] cnt;
    logic [31:0] num;
    logic [16:0] rem;
    logic [15:0] dvs;
    logic neg_q;
    logic neg_r;
    logic [15:0] q;
    logic [15:0] r;
  } div_state_t;
  div_state_t state_reg, state_next;
  logic [31:0] abs_n;
  logic [15:0] abs_d;
  logic [16:0] trial;
  logic [16:0] shifted;

  // One shift-subtract step per cycle; 32-bit dividend fits since quotient is 16 bits
  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    abs_n = wide ? dividend : {{16{signed_div & dividend[15]}}, dividend[15:0]};
    if (signed_div && abs_n[31]) begin
      abs_n = -abs_n;
    end
    abs_d = (signed_div && divisor[15]) ? -divisor : divisor;
    shifted = {state_reg.rem[15:0], state_reg.num[31]};
    trial = shifted - {1'b0, state_reg.dvs};
    if (start && !state_reg.busy) begin
      state_next.busy = 1'b1;
      state_next.cnt = 5'(STEPS);
      state_next.num = {abs_n[15:0], 16'h0000};
      state_next.rem = {1'b0, abs_n[31:16]};
      state_next.dvs = abs_d;
      state_next.neg_r = signed_div & (wide ? dividend[31] : dividend[15]);
      state_next.neg_q = state_next.neg_r ^ (signed_div & divisor[15]);
    end else if (state_reg.busy) begin
      // Overflowing quotients are not detected, as is usual for this divide
      state_next.num = {state_reg.num[30:0], ~trial[16]};
      state_next.rem = trial[16] ? shifted : trial;
      state_next.cnt = state_reg.cnt - 5'h01;
      if (state_reg.cnt == 5'h01) begin
        state_next.busy = 1'b0;
        state_next.done = 1'b1;
        state_next.q = state_reg.neg_q ? -{state_reg.num[14:0], ~trial[16]}
                                       : {state_reg.num[14:0], ~trial[16]};
        state_next.r = state_reg.neg_r ? -state_next.rem[15:0] : state_next.rem[15:0];
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign busy = state_reg.busy;
  assign done = state_reg.done;
  assign quotient = state_reg.q;
  assign remainder = state_reg.r;

  a_div_length: assert property (@(posedge core_clk) disable iff (!nrst)
    (clk_en && start && !busy) ##1 clk_en [*8] |-> busy) else $error("divide ended early");
endmodule

// ### bench/work_regs_model.sv
// Working register file model that absorbs the engine's write-backs
`timescale 1ns/1ps
module work_regs_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Write-back from the engine
  input wire alu_engine_pkg::result_t result,
  // Registers zero and one as the next instruction sees them
  output logic [15:0] reg0,
  output logic [15:0] reg1
);
  logic [15:0] regs [16]; // Register array, cleared by reset

  // Writes land on the edge that closes the result cycle; memory writes skip the array
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 16; i++) regs[i] <= 16'h0000;
    end else if (result.valid && !result.to_memory) begin
      regs[result.dest] <= result.data;
      if (result.wr2) regs[result.dest + 4'h1] <= result.data2;
    end
  end
  assign reg0 = regs[0];
  assign reg1 = regs[1];
endmodule

// ### bench/test_alu_engine.sv
// Self-checking bench for the arithmetic engine against an integer model
`timescale 1ns/1ps
module test_alu_engine;
  logic core_clk;
  logic nrst;
  logic clk_en;
  alu_engine_pkg::req_t req;
  alu_engine_pkg::core_setup_register_t cs;
  alu_engine_pkg::result_t result;
  logic [4:0] flags;
  logic [39:0] acc_a;
  logic [39:0] acc_b;
  logic issue_stall;
  logic [15:0] reg0;
  logic [15:0] reg1;
  logic [15:0] rnd; // Stimulus shift register
  logic [4:0] fl; // Expected flags
  longint ea; // Expected accumulators, kept unwrapped
  longint eb;
  int fails;
  int n_checks;

  alu_engine dut (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .req(req),
    .core_setup_register(cs), .result(result), .processor_flags_register(flags),
    .acc_a(acc_a), .acc_b(acc_b), .issue_stall(issue_stall));
  work_regs_model regs (.core_clk(core_clk), .nrst(nrst), .result(result), .reg0(reg0),
    .reg1(reg1));

  // Free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  function automatic logic [15:0] nx();
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
    return rnd;
  endfunction

  task automatic chk_w(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_l(input string nm, input logic [39:0] e, input logic [39:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    if (fails == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One request held for one edge; the registered answer is visible on return
  task automatic send(input alu_engine_pkg::op_t op, input logic bm, input logic [15:0] a,
      input logic [15:0] b, input logic [15:0] ah, input logic sel, input logic tm);
    @(posedge core_clk);
    #1;
    req = '{valid: 1'b1, op: op, byte_mode: bm, a: a, b: b, a_hi: ah, acc_sel: sel,
      to_memory: tm};
    @(posedge core_clk);
    #1;
    req.valid = 1'b0;
  endtask

  // Accumulator operation with model update; clamping follows the setup bits
  task automatic mac(input alu_engine_pkg::op_t op, input logic sel, input logic [15:0] a,
      input logic [15:0] b);
    longint p;
    longint t;
    longint c;
    longint o;
    longint lim;
    p = cs.multiply_sign_select ? longint'(a) * longint'(b)
      : longint'($signed(a)) * longint'($signed(b));
    if (cs.fractional) p = p * 2;
    c = sel ? eb : ea;
    o = sel ? ea : eb;
    case (op)
      alu_engine_pkg::OP_MPY: t = p;
      alu_engine_pkg::OP_MAC: t = c + p;
      alu_engine_pkg::OP_MSC: t = c - p;
      alu_engine_pkg::OP_AADD: t = c + o;
      alu_engine_pkg::OP_ASUB: t = c - o;
      default: t = -c;
    endcase
    lim = cs.clamp_mode_select ? 64'h0000007fffffffff : 64'h000000007fffffff;
    if (sel ? cs.acc_second_clamp_enable : cs.acc_first_clamp_enable) begin
      if (t > lim) t = lim;
      if (t < -lim - 1) t = -lim - 1;
    end
    if (sel) eb = t;
    else ea = t;
    send(op, 1'b0, a, b, 16'h0000, sel, 1'b0);
    chk_l("acc first", ea[39:0], acc_a);
    chk_l("acc second", eb[39:0], acc_b);
  endtask

  // All ALU ops in both widths; boundary operands go to the word adds at iterations 0 and 8
  task automatic alu_run();
    logic [15:0] a;
    logic [15:0] b;
    logic bm;
    int x;
    int y;
    int s;
    int r;
    int m;
    int sb;
    int sub;
    alu_engine_pkg::op_t op;
    for (int i = 0; i < 40; i++) begin
      op = alu_engine_pkg::op_t'(i % 8);
      a = (i == 0) ? 16'h7fff : (i == 8) ? 16'hffff : nx();
      b = (i == 0 || i == 8) ? 16'h0001 : nx();
      bm = (i >= 20);
      sub = (op == alu_engine_pkg::OP_SUB);
      m = bm ? 'hff : 'hffff;
      sb = bm ? 7 : 15;
      x = a & m;
      y = (sub ? ~b : b) & m;
      case (op)
        alu_engine_pkg::OP_ADD, alu_engine_pkg::OP_SUB: begin
          s = x + y + sub;
          r = s & m;
          fl[0] = s[sb + 1];
          fl[4] = ((x & 15) + (y & 15) + sub) > 15;
          fl[3] = (x[sb] == y[sb]) && (r[sb] != x[sb]);
        end
        alu_engine_pkg::OP_AND: r = a & b & m;
        alu_engine_pkg::OP_IOR: r = (a | b) & m;
        alu_engine_pkg::OP_XOR: r = (a ^ b) & m;
        alu_engine_pkg::OP_SHL: r = (a << b[3:0]) & m;
        alu_engine_pkg::OP_LSR: r = (a & m) >> b[3:0];
        default: r = (bm ? int'($signed(a[7:0])) : int'($signed(a))) >>> b[3:0] & m;
      endcase
      fl[1] = (r == 0);
      fl[2] = r[sb];
      send(op, bm, a, b, 16'h0000, 1'b0, rnd[3]);
      chk_w("alu data", r[15:0], result.data & m[15:0]);
      chk_w("alu flags", {11'h000, fl}, {11'h000, flags});
      chk_w("alu route", {15'h0000, rnd[3]}, {15'h0000, result.to_memory});
      chk_l("acc idle", ea[39:0], acc_a);
    end
  endtask

  // All six multiply modes; flags must stay as the last ALU op left them
  task automatic mul_run();
    logic [15:0] a;
    logic [15:0] b;
    longint p;
    alu_engine_pkg::op_t op;
    for (int i = 0; i < 24; i++) begin
      op = alu_engine_pkg::op_t'(8 + i % 6);
      a = nx();
      b = nx();
      if (op == alu_engine_pkg::OP_MUL_SL || op == alu_engine_pkg::OP_MUL_UL) b = b & 16'h001f;
      if (op == alu_engine_pkg::OP_MUL_B) {a, b} = {a, b} & 32'h00ff00ff;
      case (op)
        alu_engine_pkg::OP_MUL_SS: p = longint'($signed(a)) * longint'($signed(b));
        alu_engine_pkg::OP_MUL_US: p = longint'(a) * longint'($signed(b));
        alu_engine_pkg::OP_MUL_SL: p = longint'($signed(a)) * longint'(b);
        default: p = longint'(a) * longint'(b);
      endcase
      send(op, 1'b0, a, b, 16'h0000, 1'b0, 1'b0);
      chk_w("mul low", p[15:0], result.data);
      chk_w("mul high", p[31:16], result.data2);
      chk_w("mul dest", 16'h0000, {12'h000, result.dest});
      chk_w("mul flags", {11'h000, fl}, {11'h000, flags});
    end
  endtask

  // Four divide kinds; operands chosen so every quotient fits in a word
  task automatic div_run();
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] ah;
    logic [15:0] t;
    longint n;
    longint d;
    longint q;
    longint r;
    int k;
    alu_engine_pkg::op_t op;
    for (int i = 0; i < 12; i++) begin
      op = alu_engine_pkg::op_t'(16 + i % 4);
      a = nx();
      b = nx();
      t = nx();
      ah = 16'h0000;
      case (op)
        alu_engine_pkg::OP_DIV_S32: begin
          b[14] = ~b[15];
          ah = {{4{t[11]}}, t[11:0]};
          n = longint'($signed({ah, a}));
        end
        alu_engine_pkg::OP_DIV_U32: begin
          b[15] = 1'b1;
          ah = t & 16'h3fff;
          n = longint'({ah, a});
        end
        alu_engine_pkg::OP_DIV_S16: begin
          b[14] = ~b[15];
          ah = {16{a[15]}};
          n = longint'($signed(a));
        end
        default: begin
          b[0] = 1'b1;
          n = longint'(a);
        end
      endcase
      d = (op == alu_engine_pkg::OP_DIV_S32 || op == alu_engine_pkg::OP_DIV_S16)
        ? longint'($signed(b)) : longint'(b);
      q = n / d;
      r = n % d;
      send(op, 1'b0, a, b, ah, 1'b0, 1'b0);
      chk_w("div stall", 16'h0001, {15'h0000, issue_stall});
      k = 0;
      while (result.valid !== 1'b1 && k < 40) begin
        @(posedge core_clk);
        #1;
        k++;
      end
      if (k == 40) begin
        fails++;
        finish_test();
      end
      chk_w("div cycles", 16'h0011, k[15:0]);
      chk_w("quotient", q[15:0], result.data);
      chk_w("remainder", r[15:0], result.data2);
      chk_w("div dest", {12'h000, alu_engine_pkg::REG_QUOT}, {12'h000, result.dest});
      chk_w("div release", 16'h0000, {15'h0000, issue_stall});
      @(posedge core_clk);
      #1;
      chk_w("reg zero", q[15:0], reg0);
      chk_w("reg one", r[15:0], reg1);
    end
  endtask

  // Main sequence: reset, accumulator work, integer work, divides
  initial begin
    rnd = 16'h5080;
    fails = 0;
    n_checks = 0;
    nrst = 1'b0;
    clk_en = 1'b1;
    req = '0;
    cs = '0;
    fl = alu_engine_pkg::FLAGS_RESET;
    ea = 0;
    eb = 0;
    repeat (8) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    chk_w("reset flags", {11'h000, fl}, {11'h000, flags});
    for (int i = 0; i < 4; i++) begin
      cs.multiply_sign_select = i[0];
      cs.fractional = i[1];
      mac(alu_engine_pkg::OP_MPY, i[0], nx(), nx());
      mac(alu_engine_pkg::OP_MPY, ~i[0], nx(), nx());
      mac(alu_engine_pkg::OP_MAC, 1'b0, nx(), nx());
      mac(alu_engine_pkg::OP_MSC, 1'b1, nx(), nx());
      mac(alu_engine_pkg::OP_AADD, i[0], 16'h0000, 16'h0000);
      mac(alu_engine_pkg::OP_ASUB, ~i[0], 16'h0000, 16'h0000);
      mac(alu_engine_pkg::OP_ANEG, i[1], 16'h0000, 16'h0000);
    end
    // Only the first accumulator clamps; the second must run past the 32-bit limit
    cs = '0;
    cs.acc_first_clamp_enable = 1'b1;
    for (int i = 0; i < 3; i++) begin
      mac((i == 0) ? alu_engine_pkg::OP_MPY : alu_engine_pkg::OP_MAC, 1'b0, 16'h7fff,
        16'h7fff);
      mac((i == 0) ? alu_engine_pkg::OP_MPY : alu_engine_pkg::OP_MAC, 1'b1, 16'h7fff,
        16'h7fff);
    end
    cs.clamp_mode_select = 1'b1;
    mac(alu_engine_pkg::OP_MAC, 1'b0, 16'h7fff, 16'h7fff);
    alu_run();
    mul_run();
    div_run();
    finish_test();
  end
endmodule
